// file: hdl/acmp_ctrl.sv
// Local design decisions: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "acmp_map.svh"
module acmp_ctrl
	import acmp_pkg::*;
(
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	// axi4-lite slave
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [7:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// analog comparator macro
	input  wire logic        cmp_raw_i,
	output logic             comparator_power_off_o,
	output logic             bandgap_input_select_o,
	// analog pins, digital side
	input  wire logic        positive_analog_pin_i,
	input  wire logic        negative_analog_pin_i,
	output logic             positive_pin_buf_en_o,
	output logic             negative_pin_buf_en_o,
	output logic             positive_pin_port_o,
	output logic             negative_pin_port_o,
	// timer input capture front end
	input  wire logic        capture_pin_i,
	output logic             capture_src_o,
	input  wire logic        timer_capture_flag_i,
	input  wire logic        timer_capture_irq_enable_i,
	output logic             timer_capture_irq_o,
	// processor interrupt
	input  wire logic        global_irq_enable_i,
	input  wire logic        vector_ack_i,
	output logic             irq_o
);

	// ***********************************************************
	// registers and signals
	// ***********************************************************
	acmp_ctrl_type    ctrl_reg;
	acmp_pin_dis_type pin_dis_reg;
	logic             power_off_reg, bandgap_reg, flag_reg, irq_en_reg, cap_route_reg;
	logic [1:0]       mode_reg;

	logic       cmp_meta_reg;
	logic       cmp_sync_reg;
	logic       out_prev_reg;
	logic [1:0] pos_pin_sync_reg;
	logic [1:0] neg_pin_sync_reg;
	logic [1:0] cap_pin_sync_reg;

	logic       aw_ready_reg;
	logic       w_ready_reg;
	logic       aw_got_reg;
	logic       w_got_reg;
	logic [7:0] aw_addr_reg;
	logic [7:0] w_data_reg;
	logic       w_lane_reg;
	logic       b_valid_reg;
	logic [1:0] b_resp_reg;
	logic       ar_ready_reg;
	logic       r_valid_reg;
	logic [7:0] r_data_reg;
	logic [1:0] r_resp_reg;

	logic       irq_reg;
	logic       cap_src_reg;
	logic       cap_irq_reg;

	logic          cmp_out;
	logic          event_hit;
	logic          write_now;
	acmp_sel_type  wr_sel;
	acmp_sel_type  rd_sel;
	logic          flag_clear;
	logic [7:0]    rd_value;

	// ***********************************************************
	// address decode
	// ***********************************************************
	function automatic acmp_sel_type acmp_decode(input logic [7:0] addr);
		case (addr)
			`ACMP_OFF_CTRL:     acmp_decode = ACMP_SEL_CTRL;
			`ACMP_OFF_PIN_DIS:  acmp_decode = ACMP_SEL_PIN_DIS;
			`ACMP_OFF_IRQ_STAT: acmp_decode = ACMP_SEL_IRQ_STAT;
			`ACMP_OFF_IRQ_CLR:  acmp_decode = ACMP_SEL_IRQ_CLR;
			`ACMP_OFF_IRQ_EN:   acmp_decode = ACMP_SEL_IRQ_EN;
			default:            acmp_decode = ACMP_SEL_NONE;
		endcase
	endfunction : acmp_decode

	// ***********************************************************
	// synchronisers
	// ***********************************************************
	// the raw result comes from the analog macro, which does the voltage compare
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cmp_meta_reg <= 1'b0;
			cmp_sync_reg <= 1'b0;
		end else begin
			cmp_meta_reg <= cmp_raw_i;
			cmp_sync_reg <= cmp_meta_reg;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pos_pin_sync_reg <= 2'h0;
			neg_pin_sync_reg <= 2'h0;
			cap_pin_sync_reg <= 2'h0;
		end else begin
			pos_pin_sync_reg <= {pos_pin_sync_reg[0], positive_analog_pin_i};
			neg_pin_sync_reg <= {neg_pin_sync_reg[0], negative_analog_pin_i};
			cap_pin_sync_reg <= {cap_pin_sync_reg[0], capture_pin_i};
		end
	end

	// a powered-down comparator reads low; the drop can itself look like a
	// falling edge, which is why software masks the interrupt first
	assign cmp_out = cmp_sync_reg & ~ctrl_reg.power_off;

	// ***********************************************************
	// event detection
	// ***********************************************************
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			out_prev_reg <= 1'b0;
		end else begin
			out_prev_reg <= cmp_out;
		end
	end

	always_comb begin
		case (ctrl_reg.mode_sel)
			`ACMP_MODE_TOGGLE: event_hit = cmp_out ^ out_prev_reg;
			`ACMP_MODE_FALL:   event_hit = ~cmp_out & out_prev_reg;
			`ACMP_MODE_RISE:   event_hit = cmp_out & ~out_prev_reg;
			default:           event_hit = 1'b0;
		endcase
	end

	// ***********************************************************
	// bus write side
	// ***********************************************************
	assign write_now = aw_got_reg & w_got_reg;
	assign wr_sel    = acmp_decode(aw_addr_reg);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			aw_ready_reg <= 1'b0;
			aw_got_reg   <= 1'b0;
			aw_addr_reg  <= 8'h00;
		end else if (s_axi_awvalid_i && aw_ready_reg) begin
			aw_ready_reg <= 1'b0;
			aw_got_reg   <= 1'b1;
			aw_addr_reg  <= s_axi_awaddr_i;
		end else if (write_now) begin
			aw_got_reg <= 1'b0;
		end else if (!aw_got_reg && !b_valid_reg) begin
			aw_ready_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			w_ready_reg <= 1'b0;
			w_got_reg   <= 1'b0;
			w_data_reg  <= 8'h00;
			w_lane_reg  <= 1'b0;
		end else if (s_axi_wvalid_i && w_ready_reg) begin
			w_ready_reg <= 1'b0;
			w_got_reg   <= 1'b1;
			w_data_reg  <= s_axi_wdata_i[7:0];
			w_lane_reg  <= s_axi_wstrb_i[0];
		end else if (write_now) begin
			w_got_reg <= 1'b0;
		end else if (!w_got_reg && !b_valid_reg) begin
			w_ready_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			b_valid_reg <= 1'b0;
			b_resp_reg  <= `ACMP_RESP_OKAY;
		end else if (write_now) begin
			b_valid_reg <= 1'b1;
			b_resp_reg  <= (wr_sel == ACMP_SEL_NONE) ? `ACMP_RESP_SLVERR : `ACMP_RESP_OKAY;
		end else if (s_axi_bready_i) begin
			b_valid_reg <= 1'b0;
		end
	end

	// ***********************************************************
	// register file
	// ***********************************************************
	// a flag cleared by software or by the vector still sets if an event
	// arrives in the same cycle
	assign flag_clear = vector_ack_i
		| (write_now && w_lane_reg && wr_sel == ACMP_SEL_CTRL
			&& w_data_reg[`ACMP_BIT_FLAG])
		| (write_now && w_lane_reg && wr_sel == ACMP_SEL_IRQ_CLR
			&& w_data_reg[0]);

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flag_reg <= 1'b0;
		end else if (event_hit) begin
			flag_reg <= 1'b1;
		end else if (flag_clear) begin
			flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			power_off_reg <= 1'(`ACMP_RST_CTRL >> `ACMP_BIT_POWER_OFF);
			bandgap_reg   <= 1'b0;
			irq_en_reg    <= 1'b0;
			cap_route_reg <= 1'b0;
			mode_reg      <= `ACMP_MODE_TOGGLE;
		end else if (write_now && w_lane_reg && wr_sel == ACMP_SEL_CTRL) begin
			power_off_reg <= w_data_reg[`ACMP_BIT_POWER_OFF];
			bandgap_reg   <= w_data_reg[`ACMP_BIT_BANDGAP];
			irq_en_reg    <= w_data_reg[`ACMP_BIT_IRQ_EN];
			cap_route_reg <= w_data_reg[`ACMP_BIT_CAP_ROUTE];
			mode_reg      <= w_data_reg[`ACMP_BIT_MODE_HI:`ACMP_BIT_MODE_LO];
		end else if (write_now && w_lane_reg && wr_sel == ACMP_SEL_IRQ_EN) begin
			irq_en_reg <= w_data_reg[0];
		end
	end

	// packed view of the fields; the output bit is the synchronised result, forced low while power_off is set
	assign ctrl_reg = {power_off_reg, bandgap_reg, cmp_out, flag_reg,
		irq_en_reg, cap_route_reg, mode_reg};

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_dis_reg <= `ACMP_RST_PIN_DIS;
		end else if (write_now && w_lane_reg && wr_sel == ACMP_SEL_PIN_DIS) begin
			pin_dis_reg.unused      <= 6'h00;
			pin_dis_reg.neg_dig_off <= w_data_reg[`ACMP_BIT_NEG_DIG_OFF];
			pin_dis_reg.pos_dig_off <= w_data_reg[`ACMP_BIT_POS_DIG_OFF];
		end
	end

	// ***********************************************************
	// bus read side
	// ***********************************************************
	assign rd_sel = acmp_decode(s_axi_araddr_i);

	always_comb begin
		case (rd_sel)
			ACMP_SEL_CTRL:     rd_value = ctrl_reg;
			ACMP_SEL_PIN_DIS:  rd_value = pin_dis_reg;
			ACMP_SEL_IRQ_STAT: rd_value = {7'h00, ctrl_reg.event_flag};
			ACMP_SEL_IRQ_EN:   rd_value = {7'h00, ctrl_reg.irq_enable};
			default:           rd_value = 8'h00;
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			ar_ready_reg <= 1'b0;
			r_valid_reg  <= 1'b0;
			r_data_reg   <= 8'h00;
			r_resp_reg   <= `ACMP_RESP_OKAY;
		end else if (s_axi_arvalid_i && ar_ready_reg) begin
			ar_ready_reg <= 1'b0;
			r_valid_reg  <= 1'b1;
			r_data_reg   <= rd_value;
			r_resp_reg   <= (rd_sel == ACMP_SEL_NONE) ? `ACMP_RESP_SLVERR : `ACMP_RESP_OKAY;
		end else if (r_valid_reg) begin
			if (s_axi_rready_i) begin
				r_valid_reg <= 1'b0;
			end
		end else begin
			ar_ready_reg <= 1'b1;
		end
	end

	// ***********************************************************
	// pins, timer capture and interrupts
	// ***********************************************************
	// port bits are registered so a disabled pin reads zero from the next edge
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			positive_pin_port_o <= 1'b0;
			negative_pin_port_o <= 1'b0;
		end else begin
			positive_pin_port_o <= pos_pin_sync_reg[1] & ~pin_dis_reg.pos_dig_off;
			negative_pin_port_o <= neg_pin_sync_reg[1] & ~pin_dis_reg.neg_dig_off;
		end
	end

	// the timer's noise canceller and edge select follow this output, so the
	// comparator is treated exactly like the pin
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cap_src_reg <= 1'b0;
			cap_irq_reg <= 1'b0;
		end else begin
			cap_src_reg <= ctrl_reg.cap_route ? cmp_out : cap_pin_sync_reg[1];
			cap_irq_reg <= timer_capture_flag_i & timer_capture_irq_enable_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= ctrl_reg.event_flag & ctrl_reg.irq_enable & global_irq_enable_i;
		end
	end

	// ***********************************************************
	// outputs
	// ***********************************************************
	assign s_axi_awready_o        = aw_ready_reg;
	assign s_axi_wready_o         = w_ready_reg;
	assign s_axi_bvalid_o         = b_valid_reg;
	assign s_axi_bresp_o          = b_resp_reg;
	assign s_axi_arready_o        = ar_ready_reg;
	assign s_axi_rvalid_o         = r_valid_reg;
	assign s_axi_rresp_o          = r_resp_reg;
	assign s_axi_rdata_o          = {24'h000000, r_data_reg};
	assign comparator_power_off_o = ctrl_reg.power_off;
	assign bandgap_input_select_o = ctrl_reg.bandgap_sel;
	assign positive_pin_buf_en_o  = ~pin_dis_reg.pos_dig_off;
	assign negative_pin_buf_en_o  = ~pin_dis_reg.neg_dig_off;
	assign capture_src_o          = cap_src_reg;
	assign timer_capture_irq_o    = cap_irq_reg;
	assign irq_o                  = irq_reg;

endmodule : acmp_ctrl

// file: hdl/acmp_map.svh
`ifndef ACMP_MAP_SVH
`define ACMP_MAP_SVH

// register byte offsets
`define ACMP_OFF_CTRL     8'h00
`define ACMP_OFF_PIN_DIS  8'h04
`define ACMP_OFF_IRQ_STAT 8'h08
`define ACMP_OFF_IRQ_CLR  8'h0C
`define ACMP_OFF_IRQ_EN   8'h10

// control/status field positions
`define ACMP_BIT_POWER_OFF  7
`define ACMP_BIT_BANDGAP    6
`define ACMP_BIT_SYNC_OUT   5
`define ACMP_BIT_FLAG       4
`define ACMP_BIT_IRQ_EN     3
`define ACMP_BIT_CAP_ROUTE  2
`define ACMP_BIT_MODE_HI    1
`define ACMP_BIT_MODE_LO    0

// pin digital-input-disable field positions
`define ACMP_BIT_NEG_DIG_OFF 1
`define ACMP_BIT_POS_DIG_OFF 0

// event mode encodings
`define ACMP_MODE_TOGGLE   2'h0
`define ACMP_MODE_RESERVED 2'h1
`define ACMP_MODE_FALL     2'h2
`define ACMP_MODE_RISE     2'h3

// reset values
`define ACMP_RST_CTRL    8'h00
`define ACMP_RST_PIN_DIS 8'h00

// bus answers
`define ACMP_RESP_OKAY   2'h0
`define ACMP_RESP_SLVERR 2'h2

`endif

// file: hdl/acmp_pkg.sv
package acmp_pkg;

	// control/status fields, bit 7 down to bit 0
	typedef struct packed {
		logic       power_off;
		logic       bandgap_sel;
		logic       sync_out;
		logic       event_flag;
		logic       irq_enable;
		logic       cap_route;
		logic [1:0] mode_sel;
	} acmp_ctrl_type;

	// pin digital-input-disable fields
	typedef struct packed {
		logic [5:0] unused;
		logic       neg_dig_off;
		logic       pos_dig_off;
	} acmp_pin_dis_type;

	// registers reachable by software, and none for an unmapped offset
	typedef enum logic [2:0] {
		ACMP_SEL_CTRL,
		ACMP_SEL_PIN_DIS,
		ACMP_SEL_IRQ_STAT,
		ACMP_SEL_IRQ_CLR,
		ACMP_SEL_IRQ_EN,
		ACMP_SEL_NONE
	} acmp_sel_type;

endpackage : acmp_pkg

// file: dv/acmp_ctrl_asserts.sv
`timescale 1ns/100ps
// ****************************************
// bus, interrupt and pin checks at the ports
// ****************************************
module acmp_ctrl_asserts (
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	input wire logic s_axi_awvalid_i,
	input wire logic s_axi_awready_o,
	input wire logic s_axi_wvalid_i,
	input wire logic s_axi_wready_o,
	input wire logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	input wire logic s_axi_arvalid_i,
	input wire logic s_axi_arready_o,
	input wire logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	input wire logic timer_capture_flag_i,
	input wire logic timer_capture_irq_enable_i,
	input wire logic timer_capture_irq_o,
	input wire logic global_irq_enable_i,
	input wire logic irq_o,
	input wire logic positive_pin_buf_en_o,
	input wire logic positive_pin_port_o
);
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (!rstn_i);

	a_wr_answer: assert property (s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i &&
		s_axi_wready_o |-> ##[1:2] s_axi_bvalid_o) else $error("write answer late");
	a_b_release: assert property (s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o)
		else $error("bvalid held after handshake");
	a_aw_drop: assert property (s_axi_awvalid_i && s_axi_awready_o |=> !s_axi_awready_o)
		else $error("awready stayed high");
	a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
		else $error("read answer late");
	a_r_release: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o)
		else $error("rvalid held after handshake");
	a_global_gate: assert property (!global_irq_enable_i |=> !irq_o)
		else $error("irq without global enable");
	a_timer_irq: assert property (timer_capture_irq_o ==
		$past(timer_capture_flag_i && timer_capture_irq_enable_i)) else $error("timer irq wrong");
	a_pin_port_off: assert property (!positive_pin_buf_en_o &&
		$past(!positive_pin_buf_en_o) |-> !positive_pin_port_o) else $error("disabled pin reads one");

	cover property ($rose(irq_o));
	cover property ($rose(timer_capture_irq_o));
	cover property ($fell(positive_pin_buf_en_o));
endmodule : acmp_ctrl_asserts

bind acmp_ctrl acmp_ctrl_asserts u_chk (.*);

// file: dv/acmp_far_model.sv
`timescale 1ns/100ps
// ****************************************
// comparator macro and timer front end
// ****************************************
module acmp_far_model #(
	parameter logic [11:0] BANDGAP_MV = 12'h44C
) (
	input  wire logic        ref_clk_i,
	input  wire logic        rstn_i,
	input  wire logic        power_off_i,
	input  wire logic        bandgap_sel_i,
	input  wire logic        capture_src_i,
	input  wire logic [11:0] pos_mv_i,
	input  wire logic [11:0] neg_mv_i,
	output logic             cmp_raw_o,
	output logic             timer_flag_o
);
	logic toggle_reg;

	// an unpowered macro gives garbage: it flips each cycle so nothing may rely on it
	assign cmp_raw_o = power_off_i ? toggle_reg :
		((bandgap_sel_i ? BANDGAP_MV : pos_mv_i) > neg_mv_i);

	// capture front end reduced to one register stage
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			toggle_reg <= 1'h0;
			timer_flag_o <= 1'h0;
		end else begin
			toggle_reg <= ~toggle_reg;
			timer_flag_o <= capture_src_i;
		end
	end
endmodule : acmp_far_model

// file: dv/acmp_ctrl_tb.sv
`timescale 1ns/100ps
`include "acmp_map.svh"
module acmp_ctrl_tb;
	logic        ref_clk_i = 1'h0;
	logic        rstn_i = 1'h0;
	logic [7:0]  s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
	logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd;
	logic [3:0]  s_axi_wstrb_i = 4'h0;
	logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, resp;
	logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
	logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0, vector_ack_i = 1'h0;
	logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o;
	logic        s_axi_rvalid_o, cmp_raw_i, comparator_power_off_o, bandgap_input_select_o;
	logic        positive_analog_pin_i = 1'h0, negative_analog_pin_i = 1'h0, capture_pin_i = 1'h0;
	logic        positive_pin_buf_en_o, negative_pin_buf_en_o, capture_src_o;
	logic        positive_pin_port_o, negative_pin_port_o, irq_o, timer_capture_irq_o;
	logic        timer_capture_flag_i, timer_capture_irq_enable_i = 1'h0, global_irq_enable_i = 1'h0;
	logic [11:0] pos_mv = 12'h000, neg_mv = 12'h100;
	logic [7:0]  offs [4] = '{8'h00, 8'h04, 8'h08, 8'h10};
	int          bad_count = 0, checked = 0;

	always #2.5 ref_clk_i = ~ref_clk_i;

	acmp_ctrl DUT (.*);

	acmp_far_model u_far (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
		.power_off_i(comparator_power_off_o), .bandgap_sel_i(bandgap_input_select_o),
		.capture_src_i(capture_src_o), .pos_mv_i(pos_mv), .neg_mv_i(neg_mv),
		.cmp_raw_o(cmp_raw_i), .timer_flag_o(timer_capture_flag_i));

	// ****************************************
	// bus tasks and checks
	// ****************************************
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic hang;
		bad_count++;
		$display("ERROR at %0t: bus answer never came", $time);
		stop_test();
	endtask : hang

	// ready is sampled mid-cycle: it only moves on rising edges
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic ha, hw, hb;
		hb = 1'h0;
		@(posedge ref_clk_i);
		s_axi_awaddr_i <= a;
		s_axi_wdata_i <= d;
		s_axi_wstrb_i <= 4'hF;
		s_axi_awvalid_i <= 1'h1;
		s_axi_wvalid_i <= 1'h1;
		s_axi_bready_i <= 1'h1;
		for (int n = 0; n < 40 && !hb; n++) begin
			@(negedge ref_clk_i);
			ha = s_axi_awvalid_i && s_axi_awready_o;
			hw = s_axi_wvalid_i && s_axi_wready_o;
			hb = s_axi_bvalid_o;
			resp = s_axi_bresp_o;
			@(posedge ref_clk_i);
			if (ha) s_axi_awvalid_i <= 1'h0;
			if (hw) s_axi_wvalid_i <= 1'h0;
			if (hb) s_axi_bready_i <= 1'h0;
		end
		if (!hb) hang();
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a);
		logic ha, hr;
		hr = 1'h0;
		@(posedge ref_clk_i);
		s_axi_araddr_i <= a;
		s_axi_arvalid_i <= 1'h1;
		s_axi_rready_i <= 1'h1;
		for (int n = 0; n < 40 && !hr; n++) begin
			@(negedge ref_clk_i);
			ha = s_axi_arvalid_i && s_axi_arready_o;
			hr = s_axi_rvalid_o;
			rd = s_axi_rdata_o;
			resp = s_axi_rresp_o;
			@(posedge ref_clk_i);
			if (ha) s_axi_arvalid_i <= 1'h0;
			if (hr) s_axi_rready_i <= 1'h0;
		end
		if (!hr) hang();
	endtask : axi_rd

	task automatic cyc(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : cyc

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (3) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		foreach (offs[i]) begin
			axi_rd(offs[i]);
			chk(rd, 32'h0);
		end
		axi_rd(8'h14);
		chk(resp, 2'h2);
		chk(rd, 32'h0);
		axi_wr(8'h14, 32'h1);
		chk(resp, 2'h2);
		$display("reset values done");
		axi_wr(`ACMP_OFF_CTRL, 32'h40);
		chk(bandgap_input_select_o, 1'h1);
		cyc(4);
		axi_rd(`ACMP_OFF_CTRL);
		chk(rd, 32'h70);
		axi_wr(`ACMP_OFF_CTRL, 32'hC0);
		chk(comparator_power_off_o, 1'h1);
		cyc(6);
		axi_rd(`ACMP_OFF_CTRL);
		chk(rd, 32'hD0);
		axi_wr(`ACMP_OFF_CTRL, 32'h00);
		cyc(4);
		axi_wr(`ACMP_OFF_CTRL, 32'h10);
		cyc(4);
		axi_rd(`ACMP_OFF_CTRL);
		chk(rd, 32'h00);
		$display("power and bandgap done");
		for (int m = 0; m < 4; m++) begin
			axi_wr(`ACMP_OFF_CTRL, m);
			axi_wr(`ACMP_OFF_IRQ_CLR, 32'h1);
			@(posedge ref_clk_i);
			pos_mv <= 12'h200;
			cyc(4);
			axi_rd(`ACMP_OFF_IRQ_STAT);
			chk(rd, m == 0 || m == 3);
			axi_wr(`ACMP_OFF_IRQ_CLR, 32'h1);
			@(posedge ref_clk_i);
			pos_mv <= 12'h000;
			cyc(4);
			axi_rd(`ACMP_OFF_IRQ_STAT);
			chk(rd, m == 0 || m == 2);
		end
		$display("event modes done");
		axi_wr(`ACMP_OFF_CTRL, 32'h0);
		axi_wr(`ACMP_OFF_IRQ_CLR, 32'h1);
		axi_wr(`ACMP_OFF_IRQ_EN, 32'h1);
		axi_rd(`ACMP_OFF_CTRL);
		chk(rd, 32'h08);
		@(posedge ref_clk_i);
		global_irq_enable_i <= 1'h1;
		pos_mv <= 12'h200;
		cyc(5);
		chk(irq_o, 1'h1);
		@(posedge ref_clk_i);
		global_irq_enable_i <= 1'h0;
		cyc(2);
		chk(irq_o, 1'h0);
		@(posedge ref_clk_i);
		global_irq_enable_i <= 1'h1;
		axi_wr(`ACMP_OFF_IRQ_CLR, 32'h0);
		cyc(2);
		chk(irq_o, 1'h1);
		axi_wr(`ACMP_OFF_IRQ_CLR, 32'h1);
		cyc(2);
		chk(irq_o, 1'h0);
		@(posedge ref_clk_i);
		pos_mv <= 12'h000;
		cyc(5);
		chk(irq_o, 1'h1);
		@(posedge ref_clk_i);
		vector_ack_i <= 1'h1;
		@(posedge ref_clk_i);
		vector_ack_i <= 1'h0;
		cyc(2);
		chk(irq_o, 1'h0);
		axi_wr(`ACMP_OFF_IRQ_EN, 32'h0);
		@(posedge ref_clk_i);
		pos_mv <= 12'h200;
		cyc(5);
		chk(irq_o, 1'h0);
		axi_rd(`ACMP_OFF_IRQ_STAT);
		chk(rd, 32'h1);
		$display("interrupt done");
		axi_wr(`ACMP_OFF_CTRL, 32'h4);
		cyc(6);
		chk(capture_src_o, 1'h1);
		@(posedge ref_clk_i);
		timer_capture_irq_enable_i <= 1'h1;
		cyc(3);
		chk(timer_capture_irq_o, 1'h1);
		axi_wr(`ACMP_OFF_CTRL, 32'h0);
		cyc(6);
		chk({capture_src_o, timer_capture_irq_o}, 2'h0);
		@(posedge ref_clk_i);
		capture_pin_i <= 1'h1;
		cyc(6);
		chk(capture_src_o, 1'h1);
		$display("capture routing done");
		@(posedge ref_clk_i);
		positive_analog_pin_i <= 1'h1;
		negative_analog_pin_i <= 1'h1;
		cyc(4);
		chk({positive_pin_port_o, negative_pin_port_o}, 2'h3);
		axi_wr(`ACMP_OFF_PIN_DIS, 32'h3);
		cyc(4);
		chk({positive_pin_buf_en_o, negative_pin_buf_en_o, positive_pin_port_o,
			negative_pin_port_o}, 4'h0);
		axi_wr(`ACMP_OFF_PIN_DIS, 32'h2);
		cyc(4);
		chk({positive_pin_buf_en_o, negative_pin_buf_en_o, positive_pin_port_o,
			negative_pin_port_o}, 4'hA);
		axi_rd(`ACMP_OFF_PIN_DIS);
		chk(rd, 32'h2);
		$display("pin disable done");
		stop_test();
	end
endmodule : acmp_ctrl_tb
